// *** design/cbs_pkg.sv ***
// constants, field positions and carrier types of the can buffer status block
// assumes a 32-bit classic wishbone slave and a protocol engine beside it
`default_nettype none

package cbs_pkg;

  // wishbone byte offsets
  localparam logic [7:0] CBS_OFS_MASK0 = 8'h00;
  localparam logic [7:0] CBS_OFS_MASK1 = 8'h04;
  localparam logic [7:0] CBS_OFS_MASK2 = 8'h08;
  localparam logic [7:0] CBS_OFS_FULL_LO = 8'h0c;
  localparam logic [7:0] CBS_OFS_FULL_HI = 8'h10;
  localparam logic [7:0] CBS_OFS_OVF_LO = 8'h14;
  localparam logic [7:0] CBS_OFS_OVF_HI = 8'h18;
  localparam logic [7:0] CBS_OFS_CTRL0 = 8'h1c;
  localparam logic [7:0] CBS_OFS_CTRL1 = 8'h20;
  localparam logic [7:0] CBS_OFS_CTRL2 = 8'h24;
  localparam logic [7:0] CBS_OFS_CTRL3 = 8'h28;
  localparam logic [7:0] CBS_OFS_STATUS = 8'h2c;

  // reset values
  localparam logic [15:0] CBS_MASK_RST = 16'h0000;
  localparam logic [15:0] CBS_FLAG_RST = 16'h0000;
  localparam logic [7:0] CBS_CTRL_RST = 8'h00;

  // control byte fields
  localparam int CBS_B_DIR = 7;
  localparam int CBS_B_ABT = 6;
  localparam int CBS_B_LARB = 5;
  localparam int CBS_B_ERR = 4;
  localparam int CBS_B_REQ = 3;
  localparam int CBS_B_AUTO_REMOTE_REPLY_ENABLE = 2;
  localparam int CBS_B_PRI = 0;

  // buffer word layout
  localparam int CBS_W0_SID = 2;
  localparam int CBS_W0_SRR = 1;
  localparam int CBS_W0_IDE = 0;
  localparam int CBS_W1_EID = 0;
  localparam int CBS_W2_EID = 10;
  localparam int CBS_W2_RTR = 9;
  localparam int CBS_W2_RSV_HI = 8;
  localparam int CBS_W2_RSV_LO = 4;
  localparam int CBS_W2_DLC = 0;
  localparam int CBS_W7_HIT = 8;
  localparam logic [3:0] CBS_DLC_MAX = 4'h8;

  // message fields as seen by the engine
  typedef struct packed {
    logic [10:0] sid;
    logic srr;
    logic ide;
    logic [17:0] eid;
    logic rtr;
    logic [3:0] dlc;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } cbs_msg_type;

  // receive side events from the engine
  typedef struct packed {
    logic store;
    logic remote;
    logic [4:0] slot;
    logic [4:0] filter;
  } cbs_rx_event_type;

  // transmit outcome from the engine
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic done;
    logic aborted;
    logic arb_lost;
    logic bus_err;
  } cbs_tx_result_type;

  // buffer words 0 to 3 and 7
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    logic [15:0] w7;
  } cbs_words_type;

endpackage : cbs_pkg

`default_nettype wire

// *** design/cbs_slot_ctrl.sv ***
// one control byte of a message slot: direction, request, outcome flags
// assumes the engine reports one outcome per slot per cycle at most
`default_nettype none

module cbs_slot_ctrl
  import cbs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // software write of this byte
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // engine events for this slot
  input wire logic remote_i,
  input wire logic done_i,
  input wire logic aborted_i,
  input wire logic arb_lost_i,
  input wire logic bus_err_i,
  // state
  output logic [7:0] ctrl_o,
  output logic abort_req_o
);

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic abort_req_q;
  wire sw_req_set = wr_i & wdata_i[CBS_B_REQ];
  wire remote_set = remote_i & ctrl_q[CBS_B_AUTO_REMOTE_REPLY_ENABLE];
  wire req_set = sw_req_set | remote_set;
  wire sw_abort = wr_i & ~wdata_i[CBS_B_REQ] & ctrl_q[CBS_B_REQ];

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_i)
    begin
      ctrl_d[CBS_B_DIR] = wdata_i[CBS_B_DIR];
      ctrl_d[CBS_B_AUTO_REMOTE_REPLY_ENABLE] = wdata_i[CBS_B_AUTO_REMOTE_REPLY_ENABLE];
      ctrl_d[CBS_B_PRI +: 2] = wdata_i[CBS_B_PRI +: 2];
    end
    // request: set wins, then software clear, then engine completion
    if (req_set)
      ctrl_d[CBS_B_REQ] = 1'b1;
    else if (wr_i)
      ctrl_d[CBS_B_REQ] = 1'b0;
    else if (done_i | aborted_i)
      ctrl_d[CBS_B_REQ] = 1'b0;
    // outcome flags read only; a new request clears them, new events win
    ctrl_d[CBS_B_ABT] = aborted_i | (ctrl_q[CBS_B_ABT] & ~req_set);
    ctrl_d[CBS_B_LARB] = arb_lost_i | (ctrl_q[CBS_B_LARB] & ~req_set);
    ctrl_d[CBS_B_ERR] = bus_err_i | (ctrl_q[CBS_B_ERR] & ~req_set);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CBS_CTRL_RST;
      abort_req_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      abort_req_q <= sw_abort;
    end
  end

  assign ctrl_o = ctrl_q;
  assign abort_req_o = abort_req_q;

endmodule : cbs_slot_ctrl

`default_nettype wire

// *** design/cbs_msg_codec.sv ***
// packs received fields into buffer words, unpacks transmit words
// purely combinational; the caller registers the results
`default_nettype none

module cbs_msg_codec
  import cbs_pkg::*;
(
  // receive side
  input wire cbs_msg_type rx_msg_i,
  input wire logic [4:0] rx_filter_i,
  output cbs_words_type rx_words_o,
  // transmit side
  input wire cbs_words_type tx_words_i,
  output logic tx_ide_o,
  output logic [3:0] tx_dlc_o
);

  wire [3:0] raw_dlc = tx_words_i.w2[CBS_W2_DLC +: 4];

  always_comb
  begin
    rx_words_o = '0;
    rx_words_o.w0[CBS_W0_SID +: 11] = rx_msg_i.sid;
    rx_words_o.w0[CBS_W0_SRR] = rx_msg_i.srr;
    rx_words_o.w0[CBS_W0_IDE] = rx_msg_i.ide;
    rx_words_o.w1[CBS_W1_EID +: 12] = rx_msg_i.eid[17:6];
    rx_words_o.w2[CBS_W2_EID +: 6] = rx_msg_i.eid[5:0];
    rx_words_o.w2[CBS_W2_RTR] = rx_msg_i.rtr;
    rx_words_o.w2[CBS_W2_DLC +: 4] = rx_msg_i.dlc;
    rx_words_o.w3 = {rx_msg_i.byte1, rx_msg_i.byte0};
    rx_words_o.w7[CBS_W7_HIT +: 5] = rx_filter_i;
  end

  assign tx_ide_o = tx_words_i.w0[CBS_W0_IDE];
  assign tx_dlc_o = (raw_dlc > CBS_DLC_MAX) ? CBS_DLC_MAX : raw_dlc;

endmodule : cbs_msg_codec

`default_nettype wire

// *** design/cbs_buffer_status.sv ***
// register side of the can buffer status: masks, full/overflow, slot control
// assumes a classic wishbone master and a protocol engine driving the events
`default_nettype none

// Summary of operation
// - set mask bit includes identifier bit in comparison; clear bit is don't-care
// - one full flag per buffer for 32 buffers, set when buffer stored
// - full and overflow flags clear only by writing zero; ones ignored
// - overflow flag set when storing into a buffer still marked full
// - each control register holds two slots: low byte even, high byte odd
// - direction bit 7 set means transmit slot, clear means receive slot
// - aborted bit 6, arbitration lost bit 5, bus error bit 4, read only
// - setting the send request clears the three outcome flags
// - send request bit 3 starts sending; cleared after successful send
// - writing zero over a set request asks to abort the message
// - auto remote reply bit 2 sets the request on matching remote frame
// - two-bit priority orders pending slots, 11 highest, 00 lowest
// - message buffers live in external ram placed by software
// - word 0: identifier 12-2, substitute remote bit 1, extended flag bit 0
// - extended flag selects extended or standard frame format for sending
// - word 1 carries extended identifier 17-6 in bits 11-0
// - word 2: identifier 5-0, remote bit 9, reserved 8-4, length 3-0
// - word 3 holds data byte 0 low and byte 1 high
// - receive buffers get matched filter number in word 7 bits 12-8
module cbs_buffer_status
  import cbs_pkg::*;
#(
  parameter int NUM_SLOTS = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // engine events
  input wire cbs_rx_event_type rx_ev_i,
  input wire cbs_msg_type rx_msg_i,
  input wire cbs_tx_result_type tx_res_i,
  input wire cbs_words_type tx_words_i,
  // identifier comparison request
  input wire logic [1:0] cmp_mask_sel_i,
  input wire logic [15:0] cmp_msg_eid_i,
  input wire logic [15:0] cmp_flt_eid_i,
  // state towards the engine
  output logic [31:0] buf_full_o,
  output logic [31:0] buf_overrun_o,
  output logic [NUM_SLOTS-1:0] tx_pending_o,
  output logic [NUM_SLOTS-1:0] abort_req_o,
  output logic tx_pick_valid_o,
  output logic [2:0] tx_pick_slot_o,
  output logic eid_match_o,
  output cbs_words_type rx_words_o,
  output logic tx_ide_o,
  output logic [3:0] tx_dlc_o
);

  // registers
  logic [15:0] mask_q [3];
  logic [31:0] full_q;
  logic [31:0] ovf_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic eid_match_q;
  logic pick_valid_q;
  logic [2:0] pick_slot_q;
  logic [NUM_SLOTS-1:0] pending_q;
  cbs_words_type rx_words_q;
  logic tx_ide_q;
  logic [3:0] tx_dlc_q;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire hit_mask0 = (wb_adr_i == CBS_OFS_MASK0);
  wire hit_mask1 = (wb_adr_i == CBS_OFS_MASK1);
  wire hit_mask2 = (wb_adr_i == CBS_OFS_MASK2);
  wire hit_full_lo = (wb_adr_i == CBS_OFS_FULL_LO);
  wire hit_full_hi = (wb_adr_i == CBS_OFS_FULL_HI);
  wire hit_ovf_lo = (wb_adr_i == CBS_OFS_OVF_LO);
  wire hit_ovf_hi = (wb_adr_i == CBS_OFS_OVF_HI);
  wire hit_status = (wb_adr_i == CBS_OFS_STATUS);
  wire [3:0] hit_ctrl = {(wb_adr_i == CBS_OFS_CTRL3), (wb_adr_i == CBS_OFS_CTRL2),
                         (wb_adr_i == CBS_OFS_CTRL1), (wb_adr_i == CBS_OFS_CTRL0)};
  wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // write-zero-to-clear terms; ones and unselected lanes leave flags alone
  wire [15:0] clr16 = lane_mask & ~wb_dat_i[15:0];
  wire [31:0] full_clr = {(wr & hit_full_hi) ? clr16 : 16'h0000,
                          (wr & hit_full_lo) ? clr16 : 16'h0000};
  wire [31:0] ovf_clr = {(wr & hit_ovf_hi) ? clr16 : 16'h0000,
                         (wr & hit_ovf_lo) ? clr16 : 16'h0000};

  // hardware set terms
  wire [31:0] store_hot = rx_ev_i.store ? (32'h0000_0001 << rx_ev_i.slot) : 32'h0000_0000;
  wire [31:0] full_d = store_hot | (full_q & ~full_clr);
  wire [31:0] ovf_d = (store_hot & full_q) | (ovf_q & ~ovf_clr);

  // mask registers
  wire [2:0] mask_wr = {wr & hit_mask2, wr & hit_mask1, wr & hit_mask0};

  // slot control bytes
  wire [7:0] ctrl [NUM_SLOTS];
  wire [NUM_SLOTS-1:0] abort_req;

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++)
    begin : g_slot
      wire byte_wr = wr & hit_ctrl[g / 2] & wb_sel_i[g % 2];
      wire res_here = tx_res_i.valid & (tx_res_i.slot == 3'(g));
      cbs_slot_ctrl u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(byte_wr),
        .wdata_i(wb_dat_i[(g % 2) * 8 +: 8]),
        .remote_i(rx_ev_i.remote & (rx_ev_i.slot == 5'(g))),
        .done_i(res_here & tx_res_i.done),
        .aborted_i(res_here & tx_res_i.aborted),
        .arb_lost_i(res_here & tx_res_i.arb_lost),
        .bus_err_i(res_here & tx_res_i.bus_err),
        .ctrl_o(ctrl[g]),
        .abort_req_o(abort_req[g])
      );
    end
  endgenerate

  // pending transmit slots and priority pick
  logic [NUM_SLOTS-1:0] pending_d;
  logic pick_valid_d;
  logic [2:0] pick_slot_d;
  logic [1:0] best_pri;

  always_comb
  begin
    pick_valid_d = 1'b0;
    pick_slot_d = 3'h0;
    best_pri = 2'h0;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      pending_d[i] = ctrl[i][CBS_B_DIR] & ctrl[i][CBS_B_REQ];
      // strictly higher wins, so ties go to the lower slot number
      if (pending_d[i] && (!pick_valid_d || ctrl[i][CBS_B_PRI +: 2] > best_pri))
      begin
        pick_valid_d = 1'b1;
        pick_slot_d = 3'(i);
        best_pri = ctrl[i][CBS_B_PRI +: 2];
      end
    end
  end

  // identifier mask compare; selector 3 means no mask
  wire [15:0] sel_mask = (cmp_mask_sel_i == 2'h3) ? 16'h0000 : mask_q[cmp_mask_sel_i];
  wire eid_match_d = (((cmp_msg_eid_i ^ cmp_flt_eid_i) & sel_mask) == 16'h0000);

  // word codec
  cbs_words_type rx_words_d;
  logic tx_ide_d;
  logic [3:0] tx_dlc_d;

  cbs_msg_codec u_codec (
    .rx_msg_i(rx_msg_i),
    .rx_filter_i(rx_ev_i.filter),
    .rx_words_o(rx_words_d),
    .tx_words_i(tx_words_i),
    .tx_ide_o(tx_ide_d),
    .tx_dlc_o(tx_dlc_d)
  );

  // read data selection; unmapped reads return zero
  wire [2:0] ctrl_idx = hit_ctrl[3] ? 3'h6 : hit_ctrl[2] ? 3'h4 : hit_ctrl[1] ? 3'h2 : 3'h0;
  wire [15:0] ctrl_word = {ctrl[ctrl_idx + 3'h1], ctrl[ctrl_idx]};
  wire [15:0] status_word = {4'h0, pick_valid_q, pick_slot_q, pending_q};
  wire [15:0] rsel =
    hit_mask0 ? mask_q[0] :
    hit_mask1 ? mask_q[1] :
    hit_mask2 ? mask_q[2] :
    hit_full_lo ? full_q[15:0] :
    hit_full_hi ? full_q[31:16] :
    hit_ovf_lo ? ovf_q[15:0] :
    hit_ovf_hi ? ovf_q[31:16] :
    (|hit_ctrl) ? ctrl_word :
    hit_status ? status_word : 16'h0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      rdata_q <= req ? {16'h0000, rsel} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      full_q <= {CBS_FLAG_RST, CBS_FLAG_RST};
      ovf_q <= {CBS_FLAG_RST, CBS_FLAG_RST};
    end
    else
    begin
      full_q <= full_d;
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int m = 0; m < 3; m++)
    begin
      if (rst_i)
        mask_q[m] <= CBS_MASK_RST;
      else if (mask_wr[m])
        mask_q[m] <= (mask_q[m] & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pending_q <= '0;
      pick_valid_q <= 1'b0;
      pick_slot_q <= 3'h0;
      eid_match_q <= 1'b0;
      rx_words_q <= '0;
      tx_ide_q <= 1'b0;
      tx_dlc_q <= 4'h0;
    end
    else
    begin
      pending_q <= pending_d;
      pick_valid_q <= pick_valid_d;
      pick_slot_q <= pick_slot_d;
      eid_match_q <= eid_match_d;
      rx_words_q <= rx_words_d;
      tx_ide_q <= tx_ide_d;
      tx_dlc_q <= tx_dlc_d;
    end
  end

  // outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign buf_full_o = full_q;
  assign buf_overrun_o = ovf_q;
  assign tx_pending_o = pending_q;
  assign abort_req_o = abort_req;
  assign tx_pick_valid_o = pick_valid_q;
  assign tx_pick_slot_o = pick_slot_q;
  assign eid_match_o = eid_match_q;
  assign rx_words_o = rx_words_q;
  assign tx_ide_o = tx_ide_q;
  assign tx_dlc_o = tx_dlc_q;

endmodule : cbs_buffer_status

`default_nettype wire

// *** test/cbs_buffer_status_checker.sv ***
// port assertions for the can buffer status block
// assumes a single clock domain and a classic wishbone master
`default_nettype none

module cbs_buffer_status_checker
  import cbs_pkg::*;
#(
  parameter int NUM_SLOTS = 8
)
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // engine side
  input wire cbs_rx_event_type rx_ev_i,
  input wire cbs_msg_type rx_msg_i,
  input wire cbs_words_type tx_words_i,
  input wire logic [31:0] buf_full_o,
  input wire logic [31:0] buf_overrun_o,
  input wire logic [NUM_SLOTS-1:0] tx_pending_o,
  input wire logic [NUM_SLOTS-1:0] abort_req_o,
  input wire logic tx_pick_valid_o,
  input wire logic [2:0] tx_pick_slot_o,
  input wire cbs_words_type rx_words_o,
  input wire logic tx_ide_o,
  input wire logic [3:0] tx_dlc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o
    && wb_dat_o[31:16] == 16'h0000 ##1 !wb_ack_o) else $error("bus answer wrong");
  a_full_on_store: assert property (
    rx_ev_i.store |=> buf_full_o[$past(rx_ev_i.slot)]) else $error("full not set");
  a_ovf_on_full: assert property (
    rx_ev_i.store && buf_full_o[rx_ev_i.slot] |=> buf_overrun_o[$past(rx_ev_i.slot)])
    else $error("overflow not set");
  a_full_no_set: assert property (
    !rx_ev_i.store |=> (buf_full_o & ~$past(buf_full_o)) == 32'h0)
    else $error("full set without store");
  a_ovf_no_set: assert property (
    !(rx_ev_i.store && buf_full_o[rx_ev_i.slot]) |=>
    (buf_overrun_o & ~$past(buf_overrun_o)) == 32'h0) else $error("overflow set wrongly");
  a_pick_pending: assert property (
    tx_pick_valid_o == (tx_pending_o != '0) && (!tx_pick_valid_o
    || tx_pending_o[tx_pick_slot_o])) else $error("pick not pending");
  a_ide_select: assert property (
    !$past(rst_i) |-> tx_ide_o == $past(tx_words_i.w0[0])) else $error("ide wrong");
  a_dlc_clamp: assert property (
    !$past(rst_i) |-> tx_dlc_o == ($past(tx_words_i.w2[3:0]) > 4'h8 ? 4'h8
    : $past(tx_words_i.w2[3:0]))) else $error("length not clamped");
  a_word3_bytes: assert property (
    !$past(rst_i) |-> rx_words_o.w3 == $past({rx_msg_i.byte1, rx_msg_i.byte0}))
    else $error("word3 wrong");
  a_word0_sid: assert property (
    !$past(rst_i) |-> rx_words_o.w0 == $past({3'b000, rx_msg_i.sid, rx_msg_i.srr,
    rx_msg_i.ide})) else $error("word0 wrong");

  c_overflow: cover property (rx_ev_i.store && buf_full_o[rx_ev_i.slot]);
  c_abort: cover property (abort_req_o != '0);
  c_pick: cover property (tx_pick_valid_o && tx_pick_slot_o != 3'd0);
endmodule : cbs_buffer_status_checker

bind cbs_buffer_status cbs_buffer_status_checker #(.NUM_SLOTS(NUM_SLOTS))
  cbs_buffer_status_checker_inst (.*);

`default_nettype wire

// *** test/cbs_eng.sv ***
// stand-in for the protocol engine: receive events, outcomes, words
// assumes the bench calls its tasks from one process on clk_i
`default_nettype none

module cbs_eng
  import cbs_pkg::*;
(
  input wire logic clk_i,
  output var cbs_rx_event_type rx_ev_o,
  output var cbs_msg_type rx_msg_o,
  output var cbs_tx_result_type tx_res_o,
  output var cbs_words_type tx_words_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    rx_ev_o = 12'h013;
    rx_msg_o = {11'h5a3, 1'b0, 1'b1, 18'h2b3c1, 1'b1, 4'h6, 8'h11, 8'h22};
    tx_res_o = '0;
    tx_words_o = {16'h0001, 16'h0000, 16'h000f, 32'h0};
  end

  // pulse a store or a remote frame for one slot
  task automatic rx(input logic [4:0] s, input logic r);
    @(posedge clk_i);
    rx_ev_o <= {!r, r, s, 5'h13};
    @(posedge clk_i);
    rx_ev_o.store <= 1'b0;
    rx_ev_o.remote <= 1'b0;
  endtask : rx

  // res is done, aborted, arb_lost, bus_err
  task automatic tx(input logic [2:0] s, input logic [3:0] res);
    @(posedge clk_i);
    tx_res_o <= {1'b1, s, res};
    @(posedge clk_i);
    tx_res_o <= '0;
  endtask : tx

  // reserved bits of word 2 always zero
  task automatic words(input logic [3:0] dlc, input logic ide);
    @(posedge clk_i);
    tx_words_o <= {15'h0, ide, 16'h0, 12'h000, dlc, 32'h0};
  endtask : words
endmodule : cbs_eng

`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the can buffer status block
// assumes the engine stand-in drives every engine input
`default_nettype none

module testbench
  import cbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h3;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0] cmp_mask_sel_i = 2'd0;
  logic [15:0] cmp_msg_eid_i = 16'h0;
  logic [15:0] cmp_flt_eid_i = 16'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  cbs_rx_event_type rx_ev_i;
  cbs_msg_type rx_msg_i;
  cbs_tx_result_type tx_res_i;
  cbs_words_type tx_words_i;
  cbs_words_type rx_words_o;
  logic [7:0] abort_req_o;
  logic eid_match_o;
  logic tx_ide_o;
  logic [3:0] tx_dlc_o;
  logic [15:0] got;
  logic abort_seen = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  cbs_buffer_status cbs_buffer_status_inst (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .rx_ev_i, .rx_msg_i, .tx_res_i, .tx_words_i, .cmp_mask_sel_i,
    .cmp_msg_eid_i, .cmp_flt_eid_i, .buf_full_o(), .buf_overrun_o(), .tx_pending_o(),
    .abort_req_o, .tx_pick_valid_o(), .tx_pick_slot_o(), .eid_match_o, .rx_words_o,
    .tx_ide_o, .tx_dlc_o);
  cbs_eng cbs_eng_inst (.clk_i, .rx_ev_o(rx_ev_i), .rx_msg_o(rx_msg_i),
    .tx_res_o(tx_res_i), .tx_words_o(tx_words_i));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (abort_req_o[0] === 1'b1)
      abort_seen <= 1'b1;
    if (cycles == 3000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one classic cycle; read data lands in got
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    got = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    bus(1'b0, a, 16'h0000);
    chk(what, got, exp);
  endtask : rd

  task automatic cmp(input logic [1:0] s, input logic [15:0] m, input logic [15:0] f,
    input logic exp);
    @(posedge clk_i);
    cmp_mask_sel_i <= s;
    cmp_msg_eid_i <= m;
    cmp_flt_eid_i <= f;
    repeat (2) @(posedge clk_i);
    chk("id match", {15'h0, eid_match_o}, {15'h0, exp});
  endtask : cmp

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 'h30; a += 4)
      rd(a[7:0], 16'h0000, "reset value");
    $display("test reset done");
    bus(1'b1, CBS_OFS_MASK0, 16'h00ff);
    rd(CBS_OFS_MASK0, 16'h00ff, "mask0");
    cmp(2'd0, 16'h12ab, 16'h34ab, 1'b1);
    cmp(2'd0, 16'h12ab, 16'h12ac, 1'b0);
    cmp(2'd1, 16'h1234, 16'hfedc, 1'b1);
    $display("test mask done");
    cbs_eng_inst.rx(5'd5, 1'b0);
    cbs_eng_inst.rx(5'd20, 1'b0);
    rd(CBS_OFS_FULL_LO, 16'h0020, "full lo");
    rd(CBS_OFS_FULL_HI, 16'h0010, "full hi");
    cbs_eng_inst.rx(5'd5, 1'b0);
    rd(CBS_OFS_OVF_LO, 16'h0020, "overflow lo");
    bus(1'b1, CBS_OFS_FULL_LO, 16'hffff);
    rd(CBS_OFS_FULL_LO, 16'h0020, "full after ones");
    bus(1'b1, CBS_OFS_FULL_LO, 16'hffdf);
    bus(1'b1, CBS_OFS_OVF_LO, 16'h0000);
    rd(CBS_OFS_FULL_LO, 16'h0000, "full cleared");
    rd(CBS_OFS_OVF_LO, 16'h0000, "overflow cleared");
    $display("test flags done");
    bus(1'b1, CBS_OFS_CTRL0, 16'hfbf9);
    rd(CBS_OFS_CTRL0, 16'h8b89, "ctrl0");
    rd(CBS_OFS_STATUS, 16'h0903, "status");
    cbs_eng_inst.tx(3'd1, 4'b0010);
    cbs_eng_inst.tx(3'd1, 4'b0001);
    cbs_eng_inst.tx(3'd1, 4'b1000);
    rd(CBS_OFS_CTRL0, 16'hb389, "ctrl0 outcome");
    rd(CBS_OFS_STATUS, 16'h0801, "status done");
    bus(1'b1, CBS_OFS_CTRL0, 16'h8b89);
    rd(CBS_OFS_CTRL0, 16'h8b89, "ctrl0 resend");
    bus(1'b1, CBS_OFS_CTRL0, 16'h8b81);
    rd(CBS_OFS_CTRL0, 16'h8b81, "ctrl0 abort");
    chk("abort pulse", {15'h0, abort_seen}, 16'h0001);
    bus(1'b1, CBS_OFS_CTRL1, 16'h8084);
    cbs_eng_inst.rx(5'd2, 1'b1);
    cbs_eng_inst.rx(5'd3, 1'b1);
    rd(CBS_OFS_CTRL1, 16'h808c, "ctrl1 remote");
    cbs_eng_inst.tx(3'd2, 4'b0100);
    rd(CBS_OFS_CTRL1, 16'h80c4, "ctrl1 aborted");
    bus(1'b1, CBS_OFS_CTRL3, 16'h8b00);
    rd(CBS_OFS_STATUS, 16'h0982, "status tie");
    // low lane only: the odd slot of the pair must keep its byte
    wb_sel_i <= 4'h1;
    bus(1'b1, CBS_OFS_CTRL3, 16'hff81);
    wb_sel_i <= 4'h3;
    rd(CBS_OFS_CTRL3, 16'h8b81, "ctrl3 low lane");
    $display("test control done");
    chk("word0", rx_words_o.w0, {3'b000, rx_msg_i.sid, rx_msg_i.srr, rx_msg_i.ide});
    chk("word1", rx_words_o.w1, {4'h0, rx_msg_i.eid[17:6]});
    chk("word2", rx_words_o.w2, {rx_msg_i.eid[5:0], rx_msg_i.rtr, 5'h00, rx_msg_i.dlc});
    chk("word3", rx_words_o.w3, {rx_msg_i.byte1, rx_msg_i.byte0});
    chk("word7", rx_words_o.w7, 16'h1300);
    chk("tx length", {12'h0, tx_dlc_o}, 16'h0008);
    chk("tx ide", {15'h0, tx_ide_o}, 16'h0001);
    cbs_eng_inst.words(4'h3, 1'b0);
    repeat (2) @(posedge clk_i);
    chk("tx length short", {12'h0, tx_dlc_o}, 16'h0003);
    chk("tx ide std", {15'h0, tx_ide_o}, 16'h0000);
    $display("test layout done");
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
